// ==== rtl/sgl_consts.svh ====
`ifndef SGL_CONSTS_SVH
`define SGL_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and delay timebase
// ----------------------------------------------------------------------
`define SGL_CLK_NS      250'd4
`define SGL_TICK_NS     250'd100000000
`define SGL_TD_W        13
`define SGL_TD_MAX      13'h1b58
`define SGL_TD_ZERO     13'h0000

// ----------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------
`define SGL_AW          4
`define SGL_DW          16

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SGL_A_CTRL      4'h0
`define SGL_A_LL_SP     4'h1
`define SGL_A_HH_SP     4'h2
`define SGL_A_PHL       4'h3
`define SGL_A_GAIN      4'h4
`define SGL_A_OFFSET    4'h5
`define SGL_A_COEF_A    4'h6
`define SGL_A_COEF_B    4'h7
`define SGL_A_COEF_C    4'h8
`define SGL_A_COEF_D    4'h9
`define SGL_A_STATUS    4'ha
`define SGL_A_ELAPSED   4'hb
`define SGL_A_DELAY     4'hc

// ----------------------------------------------------------------------
// Setting ranges, level and power in 0.01 % steps, gain Q2.14
// ----------------------------------------------------------------------
`define SGL_LL_MIN      17'sh00000
`define SGL_LL_MAX      17'sh01194
`define SGL_HH_MIN      17'sh01194
`define SGL_HH_MAX      17'sh02328
`define SGL_PHL_MIN     17'sh00000
`define SGL_PHL_MAX     17'sh02710
`define SGL_GAIN_MIN    17'sh02000
`define SGL_GAIN_MAX    17'sh07999
`define SGL_OFS_MIN     -17'sh003e8
`define SGL_OFS_MAX     17'sh003e8
`define SGL_COEF_MIN    -17'sh08000
`define SGL_COEF_MAX    17'sh07fff
`define SGL_CB_MAX      17'sh0ffff

// ----------------------------------------------------------------------
// Reset values and fixed-point shifts
// ----------------------------------------------------------------------
`define SGL_RST_LL      16'h0bb8
`define SGL_RST_HH      16'h1f40
`define SGL_RST_PHL     16'h2710
`define SGL_RST_GAIN    16'h4000
`define SGL_RST_OFS     16'h0000
`define SGL_RST_COEF    16'h0000
`define SGL_GAIN_SHIFT  14
`define SGL_POLY_SHIFT  14
`define SGL_COEF_SHIFT  16

`endif

// ==== rtl/sgl_pkg.sv ====
package sgl_pkg;

    // Delay timer states.
    typedef enum logic [1:0] {
        SGL_IDLE,
        SGL_TIMING,
        SGL_TRIPPED
    } sgl_state_t;

    // One level loop as delivered by the input conversion.
    typedef struct packed {
        logic [15:0] level;  // Narrow range level, 0.01 % steps.
        logic        valid;  // Signal present.
        logic        oor;    // Sensor outside its range.
    } sgl_loop_t;

    // Tunable settings held by the maintenance path.
    typedef struct packed {
        logic [15:0]        ll_sp;
        logic [15:0]        hh_sp;
        logic [15:0]        power_high_limit;
        logic [15:0]        gain;
        logic signed [15:0] offset;
        logic signed [15:0] coef_a;
        logic [15:0]        coef_b;
        logic signed [15:0] coef_c;
        logic signed [15:0] coef_d;
    } sgl_cfg_t;

endpackage

// ==== rtl/sgl_trip_delay.sv ====
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "sgl_consts.svh"

module sgl_trip_delay #(
    parameter int NLOOP    = 4,
    parameter int TICK_CYC = int'(`SGL_TICK_NS / `SGL_CLK_NS)
) (
    input  wire logic                               clk_sys,      // System clock.
    input  wire logic                               rst,          // Sync reset.
    input  wire logic [`SGL_AW-1:0]                 reg_addr,     // Register index.
    input  wire logic [`SGL_DW-1:0]                 reg_wdata,    // Write data.
    input  wire logic                               reg_wr,       // Write strobe.
    input  wire logic                               reg_rd,       // Read strobe.
    output logic      [`SGL_DW-1:0]                 reg_rdata,    // Read data.
    input  wire sgl_pkg::sgl_loop_t [NLOOP-1:0]     loop_in,      // Level loops.
    input  wire logic [15:0]                        power_level,  // Delta-T power.
    input  wire logic                               dt_test,      // Delta-T on test.
    input  wire logic                               ttd_oos,      // Delay fn out.
    input  wire logic [NLOOP-1:0]                   chan_oos,     // Channel out.
    output logic      [NLOOP-1:0]                   ll_trip_n,    // Low-low, 0 trips.
    output logic      [NLOOP-1:0]                   hh_trip_n,    // High-high, 0 trips.
    output logic                                    timer_alarm,  // Timer actuated.
    output logic                                    fail_alarm    // Sensor failure.
);

    localparam int NS = NLOOP + 2;

    // ------------------------------------------------------------------
    // Test and service pins
    // ------------------------------------------------------------------

    logic [NS-1:0] sy1;
    logic [NS-1:0] sy2;
    logic [NS-1:0] sy3;
    logic [NS-1:0] sy_q;
    logic          dt_test_s;
    logic          ttd_oos_s;
    logic [NLOOP-1:0] chan_oos_s;

    // Three stages; a change is taken only once stages two and three agree,
    // so a single metastable sample can never toggle a service mode.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sy1  <= '0;
            sy2  <= '0;
            sy3  <= '0;
            sy_q <= '0;
        end else begin
            sy1  <= {dt_test, ttd_oos, chan_oos};
            sy2  <= sy1;
            sy3  <= sy2;
            sy_q <= (sy2 & sy3) | (sy_q & (sy2 | sy3));
        end
    end

    assign dt_test_s  = sy_q[NS-1];
    assign ttd_oos_s  = sy_q[NS-2];
    assign chan_oos_s = sy_q[NLOOP-1:0];

    // ------------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------------

    sgl_pkg::sgl_cfg_t cfg;
    logic              maint_en;

    // Clamp a written value into its legal setting range.
    function automatic logic [15:0] clamp(input logic signed [16:0] v,
                                          input logic signed [16:0] lo,
                                          input logic signed [16:0] hi);
        logic signed [16:0] r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return r[15:0];
    endfunction

    wire logic signed [16:0] wd_u = {1'b0, reg_wdata};
    wire logic signed [16:0] wd_s = {reg_wdata[15], reg_wdata};
    wire logic               cfg_wr = reg_wr & maint_en;

    // Settings are written only from the bus while maintenance is enabled;
    // nothing in the trip path writes them.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            maint_en   <= 1'b0;
            cfg.ll_sp  <= `SGL_RST_LL;
            cfg.hh_sp  <= `SGL_RST_HH;
            cfg.power_high_limit    <= `SGL_RST_PHL;
            cfg.gain   <= `SGL_RST_GAIN;
            cfg.offset <= `SGL_RST_OFS;
            cfg.coef_a <= `SGL_RST_COEF;
            cfg.coef_b <= `SGL_RST_COEF;
            cfg.coef_c <= `SGL_RST_COEF;
            cfg.coef_d <= `SGL_RST_COEF;
        end else begin
            if (reg_wr && reg_addr == `SGL_A_CTRL)
                maint_en <= reg_wdata[0];
            if (cfg_wr) begin
                case (reg_addr)
                    `SGL_A_LL_SP:  cfg.ll_sp  <= clamp(wd_u, `SGL_LL_MIN, `SGL_LL_MAX);
                    `SGL_A_HH_SP:  cfg.hh_sp  <= clamp(wd_u, `SGL_HH_MIN, `SGL_HH_MAX);
                    `SGL_A_PHL:    cfg.power_high_limit    <= clamp(wd_u, `SGL_PHL_MIN, `SGL_PHL_MAX);
                    `SGL_A_GAIN:   cfg.gain   <= clamp(wd_u, `SGL_GAIN_MIN, `SGL_GAIN_MAX);
                    `SGL_A_OFFSET: cfg.offset <= clamp(wd_s, `SGL_OFS_MIN, `SGL_OFS_MAX);
                    `SGL_A_COEF_A: cfg.coef_a <= clamp(wd_s, `SGL_COEF_MIN, `SGL_COEF_MAX);
                    `SGL_A_COEF_B: cfg.coef_b <= clamp(wd_u, `SGL_COEF_MIN, `SGL_CB_MAX);
                    `SGL_A_COEF_C: cfg.coef_c <= clamp(wd_s, `SGL_COEF_MIN, `SGL_COEF_MAX);
                    `SGL_A_COEF_D: cfg.coef_d <= clamp(wd_s, `SGL_COEF_MIN, `SGL_COEF_MAX);
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Level scaling and comparators
    // ------------------------------------------------------------------

    logic [NLOOP-1:0] ll_raw;
    logic [NLOOP-1:0] hh_raw;
    logic [NLOOP-1:0] eff_low;

    // Scaled level is gain times raw level plus offset, kept signed so a
    // negative offset near zero level cannot wrap into a high reading.
    for (genvar i = 0; i < NLOOP; i++) begin : g_loop
        wire logic [31:0]        prod = loop_in[i].level * cfg.gain;
        wire logic signed [18:0] scl  = 19'($signed({1'b0, prod[31:`SGL_GAIN_SHIFT]}))
                                        + 19'(cfg.offset);
        assign ll_raw[i]  = scl <= $signed({3'b000, cfg.ll_sp});
        assign hh_raw[i]  = scl >= $signed({3'b000, cfg.hh_sp});
        assign eff_low[i] = ll_raw[i] & loop_in[i].valid & ~chan_oos_s[i];
    end

    wire logic ll_any = |eff_low;

    // ------------------------------------------------------------------
    // Delay from power level
    // ------------------------------------------------------------------

    logic [15:0]           power_q;
    logic [`SGL_TD_W-1:0]  td_now;

    // delay = B * (D + P * (C + A * P)), fixed point, in 0.1 s steps.
    wire logic signed [16:0] p_s   = {1'b0, power_level};
    wire logic signed [33:0] a_p   = cfg.coef_a * p_s;
    wire logic signed [17:0] lin   = 18'(a_p >>> `SGL_COEF_SHIFT) + 18'(cfg.coef_c);
    wire logic signed [35:0] q_p   = lin * p_s;
    wire logic signed [21:0] poly  = 22'(q_p >>> `SGL_POLY_SHIFT) + 22'(cfg.coef_d);
    wire logic signed [39:0] b_p   = poly * $signed({1'b0, cfg.coef_b});
    wire logic signed [23:0] td_rw = 24'(b_p >>> `SGL_COEF_SHIFT);
    wire logic [`SGL_TD_W-1:0] td_cl =
        (td_rw < 0) ? `SGL_TD_ZERO :
        (td_rw > $signed({11'd0, `SGL_TD_MAX})) ? `SGL_TD_MAX : td_rw[`SGL_TD_W-1:0];

    // Power and its delay are registered together so they stay aligned.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power_q <= '0;
            td_now  <= `SGL_TD_ZERO;
        end else begin
            power_q <= power_level;
            td_now  <= td_cl;
        end
    end

    wire logic zero_dly = dt_test_s | ttd_oos_s | (power_q > cfg.power_high_limit);
    wire logic [`SGL_TD_W-1:0] new_dly = zero_dly ? `SGL_TD_ZERO : td_now;

    // ------------------------------------------------------------------
    // Trip delay timer
    // ------------------------------------------------------------------

    sgl_pkg::sgl_state_t   state;
    sgl_pkg::sgl_state_t   next_state;
    logic [`SGL_TD_W-1:0]  dly_lat;
    logic [`SGL_TD_W-1:0]  elapsed;
    logic [15:0]           pw_lat;
    logic [31:0]           tick_cnt;

    wire logic tick    = tick_cnt == 32'(TICK_CYC - 1);
    wire logic reached = elapsed >= dly_lat;
    wire logic pw_up   = (power_q > pw_lat) || zero_dly;
    wire logic shorter = new_dly < dly_lat;

    always_comb begin
        next_state = state;
        case (state)
            sgl_pkg::SGL_IDLE:    if (ll_any) next_state = sgl_pkg::SGL_TIMING;
            sgl_pkg::SGL_TIMING:  if (!ll_any) next_state = sgl_pkg::SGL_IDLE;
                                  else if (reached) next_state = sgl_pkg::SGL_TRIPPED;
            sgl_pkg::SGL_TRIPPED: if (!ll_any) next_state = sgl_pkg::SGL_IDLE;
            default:              next_state = sgl_pkg::SGL_IDLE;
        endcase
    end

    // The delay is latched on entry; later only a rise in power or a zero-delay mode may
    // shorten it, a fall never lengthens it again.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= sgl_pkg::SGL_IDLE;
            dly_lat <= `SGL_TD_ZERO;
            pw_lat  <= '0;
        end else begin
            state <= next_state;
            if (state == sgl_pkg::SGL_IDLE) begin
                dly_lat <= new_dly;
                pw_lat  <= power_q;
            end else if (state == sgl_pkg::SGL_TIMING && pw_up) begin
                if (power_q > pw_lat)
                    pw_lat <= power_q;
                if (shorter)
                    dly_lat <= new_dly;
            end
        end
    end

    // Timebase restarts with each timing so the first step is a full one.
    always_ff @(posedge clk_sys) begin
        if (rst || state != sgl_pkg::SGL_TIMING) begin
            tick_cnt <= '0;
            elapsed  <= `SGL_TD_ZERO;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 32'd1;
            if (tick && elapsed != `SGL_TD_MAX)
                elapsed <= elapsed + `SGL_TD_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Outputs, trip lines energized while healthy
    // ------------------------------------------------------------------

    wire logic tripped = state == sgl_pkg::SGL_TRIPPED;
    logic [NLOOP-1:0] loop_in_oor;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ll_trip_n   <= '1;
            hh_trip_n   <= '1;
            timer_alarm <= 1'b0;
            fail_alarm  <= 1'b0;
        end else begin
            ll_trip_n   <= ~(eff_low & {NLOOP{tripped}});
            hh_trip_n   <= ~(hh_raw & {NLOOP{1'b1}});
            timer_alarm <= (state != sgl_pkg::SGL_IDLE) & ~ttd_oos_s;
            fail_alarm  <= |(loop_in_oor & ~chan_oos_s);
        end
    end

    for (genvar j = 0; j < NLOOP; j++) begin : g_oor
        assign loop_in_oor[j] = loop_in[j].oor;
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------

    wire logic [15:0] status = {10'd0, zero_dly, ll_any, tripped,
                                state == sgl_pkg::SGL_TIMING, 1'b0, maint_en};
    wire logic [15:0] rd_mux =
        (reg_addr == `SGL_A_CTRL)    ? {15'd0, maint_en} :
        (reg_addr == `SGL_A_LL_SP)   ? cfg.ll_sp :
        (reg_addr == `SGL_A_HH_SP)   ? cfg.hh_sp :
        (reg_addr == `SGL_A_PHL)     ? cfg.power_high_limit :
        (reg_addr == `SGL_A_GAIN)    ? cfg.gain :
        (reg_addr == `SGL_A_OFFSET)  ? cfg.offset :
        (reg_addr == `SGL_A_COEF_A)  ? cfg.coef_a :
        (reg_addr == `SGL_A_COEF_B)  ? cfg.coef_b :
        (reg_addr == `SGL_A_COEF_C)  ? cfg.coef_c :
        (reg_addr == `SGL_A_COEF_D)  ? cfg.coef_d :
        (reg_addr == `SGL_A_STATUS)  ? status :
        (reg_addr == `SGL_A_ELAPSED) ? {3'd0, elapsed} :
        (reg_addr == `SGL_A_DELAY)   ? {3'd0, dly_lat} : 16'h0000;

    // Data stands only in the cycle after the read strobe.
    always_ff @(posedge clk_sys) begin
        if (rst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end

endmodule

// ==== verif/sgl_vote_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Voting side model
// ----------------------------------------------------------------------
module sgl_vote_model (
    input  wire logic       clk_sys,    // System clock.
    input  wire logic       rst,        // Sync reset.
    input  wire logic [3:0] ll_trip_n,  // Low-low lines, 0 trips.
    output logic            vote_trip,  // Partial trip seen.
    input  wire logic [3:0] hh_trip_n,  // High-high lines, 0 trips.
    output logic            vote_perm   // Permissive seen.
);
    // A line at zero is a trip, so a dead driver also reads as tripped.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vote_trip <= 1'b0;
            vote_perm <= 1'b0;
        end else begin
            vote_trip <= ~&ll_trip_n;
            vote_perm <= ~&hh_trip_n;
        end
    end
endmodule

// ==== verif/sgl_trip_delay_properties.sv ====
`timescale 1ns/10ps
`include "sgl_consts.svh"

// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module sgl_trip_delay_properties #(
    parameter int NLOOP    = 4,
    parameter int TICK_CYC = 25000000
) (
    input wire logic                           clk_sys,      // System clock.
    input wire logic                           rst,          // Sync reset.
    input wire logic [`SGL_AW-1:0]             reg_addr,     // Register index.
    input wire logic [`SGL_DW-1:0]             reg_wdata,    // Write data.
    input wire logic                           reg_wr,       // Write strobe.
    input wire logic                           reg_rd,       // Read strobe.
    input wire logic [`SGL_DW-1:0]             reg_rdata,    // Read data.
    input wire sgl_pkg::sgl_loop_t [NLOOP-1:0] loop_in,      // Level loops.
    input wire logic [15:0]                    power_level,  // Delta-T power.
    input wire logic                           dt_test,      // Delta-T on test.
    input wire logic                           ttd_oos,      // Delay fn out.
    input wire logic [NLOOP-1:0]               chan_oos,     // Channel out.
    input wire logic [NLOOP-1:0]               ll_trip_n,    // Low-low lines.
    input wire logic [NLOOP-1:0]               hh_trip_n,    // High-high lines.
    input wire logic                           timer_alarm,  // Timer actuated.
    input wire logic                           fail_alarm    // Sensor failure.
);
    logic [NLOOP-1:0] oor_v;
    logic [NLOOP-1:0] val_v;
    logic [2:0]       oos_hi;
    logic [2:0]       oos_lo;
    logic [2:0]       dt_hi;

    // Loop flags pulled out of the packed carrier.
    always_comb begin
        for (int i = 0; i < NLOOP; i++) begin
            oor_v[i] = loop_in[i].oor;
            val_v[i] = loop_in[i].valid;
        end
    end

    // Settle counters; the pins pass three sync stages, so 7 means settled.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oos_hi <= 3'h0;
            oos_lo <= 3'h0;
            dt_hi  <= 3'h0;
        end else begin
            oos_hi <= ttd_oos ? oos_hi + {2'h0, oos_hi != 3'h7} : 3'h0;
            oos_lo <= !ttd_oos ? oos_lo + {2'h0, oos_lo != 3'h7} : 3'h0;
            dt_hi  <= dt_test ? dt_hi + {2'h0, dt_hi != 3'h7} : 3'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_reset_out: assert property (disable iff (1'b0)
        rst |=> ll_trip_n == '1 && hh_trip_n == '1 && !timer_alarm && !fail_alarm)
        else $error("outputs not in safe state after reset");
    chk_fail_raise: assert property (
        (oor_v[0] && !chan_oos[0]) [*6] |-> fail_alarm)
        else $error("fail alarm missing for sensor fault");
    chk_fail_mute: assert property (
        ((oor_v & ~chan_oos) == '0) [*6] |-> !fail_alarm)
        else $error("fail alarm without unmuted sensor fault");
    chk_loss_release: assert property (
        !val_v[1] [*4] |-> ll_trip_n[1])
        else $error("lost loop still tripped");
    chk_alarm_mute: assert property (
        oos_hi == 3'h7 |-> !timer_alarm)
        else $error("timer alarm while delay function out");
    chk_trip_alarm: assert property (
        ll_trip_n != '1 && oos_lo == 3'h7 |-> timer_alarm)
        else $error("trip without timer alarm");
    chk_zero_delay: assert property (
        $rose(timer_alarm) && dt_hi == 3'h7 |=> ll_trip_n != '1)
        else $error("test mode did not trip at once");
    chk_trip_timed: assert property (
        $fell(ll_trip_n[0]) && oos_lo == 3'h7 |-> $past(timer_alarm))
        else $error("trip without running timer");
    chk_chan_out: assert property (
        chan_oos[2] [*6] |-> ll_trip_n[2])
        else $error("channel out of service still trips");
endmodule

bind sgl_trip_delay sgl_trip_delay_properties #(
    .NLOOP    (NLOOP),
    .TICK_CYC (TICK_CYC)
) chk_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_in(loop_in),
    .power_level(power_level), .dt_test(dt_test), .ttd_oos(ttd_oos),
    .chan_oos(chan_oos), .ll_trip_n(ll_trip_n), .hh_trip_n(hh_trip_n),
    .timer_alarm(timer_alarm), .fail_alarm(fail_alarm)
);

// ==== verif/steam_level_trip_delay_test.sv ====
`timescale 1ns/10ps
`include "sgl_consts.svh"

module steam_level_trip_delay_test;
    logic                     clk_sys;
    logic                     rst;
    logic [3:0]               reg_addr;
    logic [15:0]              reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [15:0]              reg_rdata;
    sgl_pkg::sgl_loop_t [3:0] loop_in;
    logic [15:0]              power_level;
    logic                     dt_test;
    logic                     ttd_oos;
    logic [3:0]               chan_oos;
    logic [3:0]               ll_trip_n;
    logic [3:0]               hh_trip_n;
    logic                     timer_alarm;
    logic                     fail_alarm;
    logic                     vote_trip;
    logic                     vote_perm;
    logic [3:0]               ex;
    logic [15:0]              rv;
    int                       failures;
    int                       n_compared;
    int                       seed;
    int                       cyc;
    int                       t0;
    int                       n;
    logic [3:0]  ka [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    logic [15:0] kd [9] = '{16'h0bb8, 16'h1f40, 16'h2328, 16'h6000, 16'hff38,
                            16'h0000, 16'h8000, 16'hc000, 16'h03e8};
    logic [15:0] cw [5] = '{16'h1388, 16'h251c, 16'h2ee0, 16'h1000, 16'h07d0};
    logic [15:0] ce [5] = '{16'h1194, 16'h2328, 16'h2710, 16'h2000, 16'h03e8};

    sgl_trip_delay #(.NLOOP(4), .TICK_CYC(4)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_in(loop_in),
        .power_level(power_level), .dt_test(dt_test), .ttd_oos(ttd_oos),
        .chan_oos(chan_oos), .ll_trip_n(ll_trip_n), .hh_trip_n(hh_trip_n),
        .timer_alarm(timer_alarm), .fail_alarm(fail_alarm));
    sgl_vote_model vote_u (.clk_sys(clk_sys), .rst(rst), .ll_trip_n(ll_trip_n),
        .vote_trip(vote_trip), .hh_trip_n(hh_trip_n), .vote_perm(vote_perm));

    // Clock, 4 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Cycle count doubles as the hang guard; the full run needs about 530.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task set_lvl(input int i, input logic [15:0] v);
        @(posedge clk_sys);
        loop_in[i].level <= v;
        #1 t0 = cyc;
    endtask

    task wait_trip;
        for (int k = 0; k < 300 && ll_trip_n == 4'hf; k++) begin
            tick(1);
        end
        n = cyc - t0;
    endtask

    task restore;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            loop_in[i].level <= 16'h1388;
            loop_in[i].valid <= 1'b1;
        end
        tick(5);
        check(ll_trip_n, 16'h000f);
        check(timer_alarm, 16'h0000);
    endtask

    // Gain 1.5 and offset -2 % are loaded before the random pass.
    function automatic logic hh_exp(input int l);
        return ((l * 24576) >>> 14) - 200 < 8000;
    endfunction

    initial begin
        seed = 94;
        failures = 0;
        n_compared = 0;
        cyc = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        power_level = 16'h1388;
        dt_test = 1'b0;
        ttd_oos = 1'b0;
        chan_oos = 4'h0;
        for (int i = 0; i < 4; i++) begin
            loop_in[i] = '{level: 16'h1388, valid: 1'b1, oor: 1'b0};
        end
        tick(20);
        rst <= 1'b0;
        tick(4);
        rd(`SGL_A_PHL);
        check(rv, `SGL_RST_PHL);
        wr(`SGL_A_LL_SP, 16'h0064);
        rd(`SGL_A_LL_SP);
        check(rv, `SGL_RST_LL);
        wr(`SGL_A_CTRL, 16'h0001);
        for (int k = 0; k < 5; k++) begin
            wr(ka[k], cw[k]);
            rd(ka[k]);
            check(rv, ce[k]);
        end
        rd(4'hd);
        check(rv, 16'h0000);
        for (int k = 0; k < 9; k++) begin
            wr(ka[k], kd[k]);
        end
        // Random levels against the high-high comparator.
        repeat (16) begin
            @(posedge clk_sys);
            for (int i = 0; i < 4; i++) begin
                n = 4000 + ({$random(seed)} % 5000);
                loop_in[i].level <= n[15:0];
                ex[i] = hh_exp(n);
            end
            tick(3);
            check(hh_trip_n, ex);
            check(vote_perm, ~&ex);
            check(ll_trip_n, 16'h000f);
        end
        wr(`SGL_A_GAIN, 16'h4000);
        wr(`SGL_A_OFFSET, 16'h0000);
        restore();
        // Above the power high limit the trip passes at once, per loop.
        @(posedge clk_sys);
        power_level <= 16'h251c;
        set_lvl(0, 16'h07d0);
        wait_trip();
        check(n >= 3 && n <= 5, 16'h0001);
        check(ll_trip_n, 16'h000e);
        set_lvl(1, 16'h07d0);
        tick(3);
        check(ll_trip_n, 16'h000c);
        check(vote_trip, 16'h0001);
        set_lvl(0, 16'h1388);
        tick(4);
        check(ll_trip_n, 16'h000d);
        restore();
        // Delay of 10 steps; the later fall in power must not stretch it.
        @(posedge clk_sys);
        power_level <= 16'h03d4;
        set_lvl(2, 16'h07d0);
        tick(8);
        power_level <= 16'h03c0;
        rd(`SGL_A_DELAY);
        check(rv, 16'h000a);
        wait_trip();
        check(n >= 40 && n <= 50, 16'h0001);
        restore();
        // Delay of 20 steps, cut to 5 by rising power.
        set_lvl(3, 16'h07d0);
        tick(8);
        power_level <= 16'h03de;
        tick(1);
        rd(`SGL_A_DELAY);
        check(rv, 16'h0005);
        wait_trip();
        check(n >= 18 && n <= 30, 16'h0001);
        restore();
        // Either test mode forces zero delay; out of service mutes the alarm.
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            dt_test <= (m == 0);
            ttd_oos <= (m == 1);
            power_level <= 16'h03c0;
            tick(7);
            set_lvl(0, 16'h07d0);
            wait_trip();
            check(n >= 3 && n <= 5, 16'h0001);
            check(timer_alarm, m == 0);
            restore();
        end
        @(posedge clk_sys);
        dt_test <= 1'b0;
        ttd_oos <= 1'b0;
        tick(7);
        // Loss of signal mid-count returns the path to untimed.
        set_lvl(1, 16'h07d0);
        tick(10);
        loop_in[1].valid <= 1'b0;
        tick(90);
        check(timer_alarm, 16'h0000);
        check(ll_trip_n, 16'h000f);
        restore();
        // A channel under test never starts the timer.
        @(posedge clk_sys);
        chan_oos[2] <= 1'b1;
        tick(6);
        set_lvl(2, 16'h07d0);
        tick(100);
        check(ll_trip_n, 16'h000f);
        check(timer_alarm, 16'h0000);
        // Sensor out of range, then muted by its channel going out.
        loop_in[0].oor <= 1'b1;
        tick(7);
        check(fail_alarm, 16'h0001);
        chan_oos[0] <= 1'b1;
        tick(7);
        check(fail_alarm, 16'h0000);
        report_and_stop();
    end
endmodule
